// File: rtl/hio_pkg.sv
// package of offsets, fields, reset values and timing for the host interrupt output stage
package hio_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] HIO_OFS_CONFIG = 8'h54;
	localparam logic [7:0] HIO_OFS_STATUS = 8'h58;
	localparam logic [7:0] HIO_OFS_ENABLE = 8'h5c;
	// ==========================================
	// field positions of the interrupt output configuration, and the wake source bit of status and enable
	localparam int HIO_CFG_INTERVAL_LSB = 24;
	localparam int HIO_CFG_INTERVAL_MSB = 31;
	localparam int HIO_CFG_RESTART_BIT = 14;
	localparam int HIO_CFG_ACTIVE_BIT = 13;
	localparam int HIO_CFG_MASTER_BIT = 12;
	localparam int HIO_CFG_ENABLE_BIT = 8;
	localparam int HIO_CFG_POLARITY_BIT = 4;
	localparam int HIO_CFG_BUFTYPE_BIT = 0;
	localparam int HIO_WAKE_BIT = 17;
	// ==========================================
	// reset values
	localparam logic [31:0] HIO_CONFIG_RESET = 32'h00000000;
	localparam logic [31:0] HIO_STATUS_RESET = 32'h00000000;
	localparam logic [31:0] HIO_ENABLE_RESET = 32'h00000000;
	// ==========================================
	// timing: hold-off unit in microseconds, clock in MHz
	localparam int HIO_UNIT_US = 10;
	localparam int HIO_CLK_MHZ = 125;
	localparam int HIO_UNIT_CYCLES = HIO_UNIT_US * HIO_CLK_MHZ;
	// ==========================================
	// configuration carrier
	typedef struct packed {
		logic [7:0] interval;
		logic irq_enable;
		logic polarity;
		logic push_pull;
	} hio_cfg_t;
endpackage

// File: rtl/hio_holdoff_timer.sv
// hold-off interval timer counting whole units of a fixed cycle length
`timescale 1ns/100ps
module hio_holdoff_timer
	import hio_pkg::*;
#(
	parameter int UNIT_CYCLES = HIO_UNIT_CYCLES
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic start,
	input wire logic [7:0] interval,
	output logic active
);
	// ==========================================
	// elaboration check
	// prescaler is sixteen bits wide, so longer units cannot be counted
	if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65536)
		$error("unit length out of range");

	// ==========================================
	// state
	logic [15:0] prescale_reg;
	logic [15:0] prescale_next;
	logic [7:0] units_reg;
	logic [7:0] units_next;
	logic [7:0] limit_reg;
	logic [7:0] limit_next;
	logic active_reg;
	logic active_next;

	localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);

	always_comb
	begin
		prescale_next = prescale_reg;
		units_next = units_reg;
		limit_next = limit_reg;
		active_next = active_reg;
		if (clear)
		begin
			// zero interval drops the hold-off and resets the count
			prescale_next = 16'h0000;
			units_next = 8'h00;
			active_next = 1'b0;
		end
		else if (start)
		begin
			// interval latched here, so a later nonzero write only affects later interrupts
			prescale_next = 16'h0000;
			units_next = 8'h00;
			limit_next = interval;
			active_next = 1'b1;
		end
		else if (active_reg)
		begin
			if (prescale_reg == UNIT_LAST)
			begin
				prescale_next = 16'h0000;
				units_next = units_reg + 8'h01;
				if (units_reg + 8'h01 == limit_reg)
					active_next = 1'b0;
			end
			else
				prescale_next = prescale_reg + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prescale_reg <= 16'h0000;
			units_reg <= 8'h00;
			limit_reg <= 8'h00;
			active_reg <= 1'b0;
		end
		else
		begin
			prescale_reg <= prescale_next;
			units_reg <= units_next;
			limit_reg <= limit_next;
			active_reg <= active_next;
		end
	end

	assign active = active_reg;
endmodule

// File: rtl/hio_irq_output.sv
// host interrupt output stage: status, enable, configuration and request pin
`timescale 1ns/100ps
module hio_irq_output
	import hio_pkg::*;
#(
	parameter int UNIT_CYCLES = HIO_UNIT_CYCLES
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic soft_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] irq_sources,
	output logic irq_out,
	output logic irq_oe
);
	// ==========================================
	// register state
	hio_cfg_t cfg_reg;
	hio_cfg_t cfg_next;
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [31:0] enable_reg;
	logic [31:0] enable_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic deliver_reg;
	logic deliver_next;

	logic wr_cfg;
	logic wr_status;
	logic wr_enable;
	logic master;
	logic wake;
	logic deliver;
	logic request;
	logic holdoff_active;
	logic holdoff_clear;
	logic holdoff_start;
	logic [31:0] cfg_view;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign wr_cfg = reg_wr && hit(reg_addr, HIO_OFS_CONFIG);
	assign wr_status = reg_wr && hit(reg_addr, HIO_OFS_STATUS);
	assign wr_enable = reg_wr && hit(reg_addr, HIO_OFS_ENABLE);

	// ==========================================
	// interrupt lines
	assign master = |(status_reg & enable_reg);
	assign wake = status_reg[HIO_WAKE_BIT] && enable_reg[HIO_WAKE_BIT];
	// wake source excluded so its ack never opens a hold-off window
	assign deliver = |(status_reg & enable_reg & ~(32'h1 << HIO_WAKE_BIT)) && !holdoff_active;
	assign request = cfg_reg.irq_enable && (deliver || wake);
	assign holdoff_clear = soft_rst || cfg_reg.interval == 8'h00;
	assign holdoff_start = (deliver_reg && !deliver) || (wr_cfg && reg_wdata[HIO_CFG_RESTART_BIT]);

	hio_holdoff_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_timer (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clear(holdoff_clear),
		.start(holdoff_start),
		.interval(cfg_reg.interval),
		.active(holdoff_active)
	);

	always_comb
	begin
		cfg_view = 32'h00000000;
		cfg_view[HIO_CFG_INTERVAL_MSB:HIO_CFG_INTERVAL_LSB] = cfg_reg.interval;
		cfg_view[HIO_CFG_ACTIVE_BIT] = holdoff_active;
		cfg_view[HIO_CFG_MASTER_BIT] = master;
		cfg_view[HIO_CFG_ENABLE_BIT] = cfg_reg.irq_enable;
		cfg_view[HIO_CFG_POLARITY_BIT] = cfg_reg.polarity;
		cfg_view[HIO_CFG_BUFTYPE_BIT] = cfg_reg.push_pull;
	end

	// ==========================================
	// register next values
	always_comb
	begin
		cfg_next = cfg_reg;
		status_next = status_reg;
		enable_next = enable_reg;
		rdata_next = rdata_reg;
		deliver_next = request && !wake ? deliver : 1'b0;
		if (wr_cfg)
		begin
			cfg_next.interval = reg_wdata[HIO_CFG_INTERVAL_MSB:HIO_CFG_INTERVAL_LSB];
			cfg_next.irq_enable = reg_wdata[HIO_CFG_ENABLE_BIT];
			cfg_next.polarity = reg_wdata[HIO_CFG_POLARITY_BIT];
			cfg_next.push_pull = reg_wdata[HIO_CFG_BUFTYPE_BIT];
		end
		if (wr_status)
			status_next = status_reg & ~reg_wdata;
		status_next = status_next | irq_sources; // set wins over clear
		if (wr_enable)
			enable_next = reg_wdata;
		if (reg_rd)
		begin
			if (hit(reg_addr, HIO_OFS_CONFIG))
				rdata_next = cfg_view;
			else if (hit(reg_addr, HIO_OFS_STATUS))
				rdata_next = status_reg;
			else if (hit(reg_addr, HIO_OFS_ENABLE))
				rdata_next = enable_reg;
			else
				rdata_next = 32'h00000000;
		end
		if (soft_rst)
		begin
			// buffer type is the only field kept across software reset
			cfg_next.interval = HIO_CONFIG_RESET[HIO_CFG_INTERVAL_MSB:HIO_CFG_INTERVAL_LSB];
			cfg_next.irq_enable = HIO_CONFIG_RESET[HIO_CFG_ENABLE_BIT];
			cfg_next.polarity = HIO_CONFIG_RESET[HIO_CFG_POLARITY_BIT];
			status_next = HIO_STATUS_RESET;
			enable_next = HIO_ENABLE_RESET;
			deliver_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg_reg.interval <= HIO_CONFIG_RESET[HIO_CFG_INTERVAL_MSB:HIO_CFG_INTERVAL_LSB];
			cfg_reg.irq_enable <= HIO_CONFIG_RESET[HIO_CFG_ENABLE_BIT];
			cfg_reg.polarity <= HIO_CONFIG_RESET[HIO_CFG_POLARITY_BIT];
			cfg_reg.push_pull <= HIO_CONFIG_RESET[HIO_CFG_BUFTYPE_BIT];
			status_reg <= HIO_STATUS_RESET;
			enable_reg <= HIO_ENABLE_RESET;
			rdata_reg <= 32'h00000000;
			deliver_reg <= 1'b0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			status_reg <= status_next;
			enable_reg <= enable_next;
			rdata_reg <= rdata_next;
			deliver_reg <= deliver_next;
		end
	end

	// ==========================================
	// pin drive: open-drain pulls low only while requesting
	assign irq_out = cfg_reg.push_pull ? (cfg_reg.polarity ? request : !request) : 1'b0;
	assign irq_oe = cfg_reg.push_pull ? 1'b1 : request;
	assign reg_rdata = rdata_reg;

	// ==========================================
	// assertions
	holdoff_start_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		holdoff_start && !holdoff_clear |=> holdoff_active)
		else $error("hold-off did not start");
	zero_interval_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_cfg && reg_wdata[31:24] == 8'h00 |=> ##1 !holdoff_active)
		else $error("zero interval left hold-off running");
	wake_bypass_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		wake && cfg_reg.irq_enable |-> request)
		else $error("wake event was held off");
	holdoff_withhold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		holdoff_active && !wake |-> !request)
		else $error("request leaked during hold-off");
	master_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		reg_rd && hit(reg_addr, HIO_OFS_CONFIG) |=> reg_rdata[12] == $past(master))
		else $error("master bit read wrong");
	enable_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!cfg_reg.irq_enable |-> !request)
		else $error("request while output disabled");
	polarity_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		cfg_reg.push_pull |-> irq_oe && irq_out == (request ~^ cfg_reg.polarity))
		else $error("push-pull level wrong");
	open_drain_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!cfg_reg.push_pull |-> !irq_out && irq_oe == request)
		else $error("open-drain drive wrong");
	buftype_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		soft_rst |=> cfg_reg.push_pull == $past(cfg_reg.push_pull))
		else $error("buffer type lost on soft reset");
	status_ack_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_status && reg_wdata[0] && !irq_sources[0] && !soft_rst |=> !status_reg[0])
		else $error("status bit not cleared");
	master_form_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		cfg_view[12] == |(status_reg & enable_reg))
		else $error("master line mismatch");
	restart_begins_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_cfg && reg_wdata[HIO_CFG_RESTART_BIT] && cfg_reg.interval != 8'h00 && !soft_rst |=> holdoff_active)
		else $error("restart did not open hold-off");
	zero_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		cfg_reg.interval == 8'h00 |=> !holdoff_active)
		else $error("hold-off ran with zero interval");
	open_window_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!holdoff_active && cfg_reg.irq_enable && master |-> request)
		else $error("request missing outside hold-off");
	holdoff_cause_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(holdoff_active) |-> $past(holdoff_start))
		else $error("hold-off began without cause");
	soft_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		soft_rst |=> status_reg == HIO_STATUS_RESET && enable_reg == HIO_ENABLE_RESET && !holdoff_active)
		else $error("soft reset left state behind");
endmodule

// File: sim/hio_host_model.sv
// host side of the request pin: pull-up on the shared line
`timescale 1ns/100ps
module hio_host_model
(
	input wire logic irq_out,
	input wire logic irq_oe,
	output logic pin_level
);
	// ==========================================
	// line resolution
	// a released open-drain line floats up, never keeps the last level
	assign pin_level = irq_oe ? irq_out : 1'b1;
endmodule

// File: sim/test_host_interrupt_output_control.sv
// self-checking bench for the host interrupt output stage
`timescale 1ns/100ps
module test_host_interrupt_output_control;
	import hio_pkg::*;
	// ==========================================
	// signals
	localparam int UC = 4;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic soft_rst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [31:0] reg_rdata;
	logic [31:0] irq_sources = 32'h00000000;
	logic irq_out;
	logic irq_oe;
	logic pin_level;
	logic [31:0] rv;
	logic [31:0] d;
	hio_cfg_t cfg;
	integer seed = 32'h2649;
	int fails = 0;
	int n_checks = 0;
	int k;
	always #4 core_clk = ~core_clk;
	hio_irq_output #(.UNIT_CYCLES(UC)) hio_irq_output_i (.core_clk(core_clk), .arst_n(arst_n),
		.soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .irq_sources(irq_sources), .irq_out(irq_out), .irq_oe(irq_oe));
	hio_host_model hio_host_model_i (.irq_out(irq_out), .irq_oe(irq_oe), .pin_level(pin_level));
	// ==========================================
	// helpers
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			fails++;
		end
	endtask
	task wrap_up;
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		rv = reg_rdata;
	endtask
	task pulse(input logic [31:0] v);
		@(negedge core_clk);
		irq_sources = v;
		@(negedge core_clk);
		irq_sources = 32'h00000000;
	endtask
	function logic [31:0] cfg_word(input hio_cfg_t c);
		return {c.interval, 15'h0000, c.irq_enable, 3'h0, c.polarity, 3'h0, c.push_pull};
	endfunction
	// pin level a host sees for a given request
	function logic exp_level(input hio_cfg_t c, input logic req);
		return c.push_pull ? (req ? c.polarity : ~c.polarity) : ~req;
	endfunction
	// ==========================================
	// watchdog, generous against about a hundred cycles of tests
	initial
	begin
		#200000;
		fails++;
		wrap_up();
	end
	// ==========================================
	// scenarios
	initial
	begin
		repeat (8) @(negedge core_clk);
		arst_n = 1'b1;
		rd(HIO_OFS_CONFIG);
		check(rv, HIO_CONFIG_RESET);
		rd(HIO_OFS_STATUS);
		check(rv, HIO_STATUS_RESET);
		rd(HIO_OFS_ENABLE);
		check(rv, HIO_ENABLE_RESET);
		rd(8'h60);
		check(rv, 32'h00000000);
		check(irq_oe, 1'b0);
		for (k = 0; k < 4; k++)
		begin
			d = $random(seed);
			wr(HIO_OFS_ENABLE, d);
			rd(HIO_OFS_ENABLE);
			check(rv, d);
		end
		wr(HIO_OFS_ENABLE, 32'h00020001);
		cfg = '{interval: 8'h00, irq_enable: 1'b1, polarity: 1'b1, push_pull: 1'b0};
		wr(HIO_OFS_CONFIG, cfg_word(cfg));
		// enabled source 0 raises the master line; unenabled random sources ride along unchecked
		pulse(32'h00000001 | ($random(seed) & 32'h00000f00));
		check(pin_level, exp_level(cfg, 1'b1));
		rd(HIO_OFS_CONFIG);
		check(rv[12], 1'b1);
		wr(HIO_OFS_STATUS, 32'h00000000);
		rd(HIO_OFS_STATUS);
		check(rv[0], 1'b1);
		cfg.irq_enable = 1'b0;
		wr(HIO_OFS_CONFIG, cfg_word(cfg));
		check(pin_level, 1'b1);
		rd(HIO_OFS_CONFIG);
		check(rv[12], 1'b1);
		for (k = 0; k < 2; k++)
		begin
			cfg = '{interval: 8'h00, irq_enable: 1'b1, polarity: k[0], push_pull: 1'b1};
			wr(HIO_OFS_CONFIG, cfg_word(cfg));
			check(irq_oe, 1'b1);
			check(pin_level, exp_level(cfg, 1'b1));
		end
		@(negedge core_clk);
		soft_rst = 1'b1;
		@(negedge core_clk);
		soft_rst = 1'b0;
		rd(HIO_OFS_CONFIG);
		check(rv, 32'h00000001);
		// hold-off of two units
		wr(HIO_OFS_ENABLE, 32'h00020001);
		cfg = '{interval: 8'h02, irq_enable: 1'b1, polarity: 1'b0, push_pull: 1'b0};
		wr(HIO_OFS_CONFIG, cfg_word(cfg));
		pulse(32'h00000001);
		check(pin_level, 1'b0);
		wr(HIO_OFS_STATUS, 32'hffffffff);
		check(pin_level, 1'b1);
		rd(HIO_OFS_CONFIG);
		check(rv[13], 1'b1);
		pulse(32'h00000001);
		check(pin_level, 1'b1);
		k = 0;
		while (pin_level !== 1'b0 && k < 40)
		begin
			@(negedge core_clk);
			k++;
		end
		check(k > 0 && k <= 2 * UC, 1'b1);
		// longer interval applies to the next hold-off
		cfg.interval = 8'h10;
		wr(HIO_OFS_CONFIG, cfg_word(cfg));
		wr(HIO_OFS_STATUS, 32'h00000001);
		pulse(32'h00020000);
		check(pin_level, 1'b0);
		wr(HIO_OFS_STATUS, 32'h00020000);
		pulse(32'h00000001);
		check(pin_level, 1'b1);
		cfg.interval = 8'h00;
		wr(HIO_OFS_CONFIG, cfg_word(cfg));
		// timer sees the zero interval one edge after the write
		@(negedge core_clk);
		check(pin_level, 1'b0);
		// restart withholds a pending request; ignored while the interval is still zero
		cfg.interval = 8'h02;
		wr(HIO_OFS_CONFIG, cfg_word(cfg));
		check(pin_level, 1'b0);
		wr(HIO_OFS_CONFIG, cfg_word(cfg) | 32'h00004000);
		check(pin_level, 1'b1);
		rd(HIO_OFS_CONFIG);
		check(rv[14:13], 2'b01);
		wrap_up();
	end
endmodule
